// File: logic/scc_sysref_ctrl.sv
// Purpose: Control register bank for the alignment (SYSREF) capture path
// Assumes: Serial port logic delivers address, write strobe and data on clk_i
// Notes:   Position status comes from the position detector outside this bank
//
// Function
// - Alignment events pass only while processor enable bit 6 and receiver enable bit 5 are both one; bit 6 resets zero.
// - Receiver circuit enabled while bit 5 is one; resets zero.
// - Fine step bit 4 selects smaller window delay steps.
// - Capture delay tap chosen by bits 3:0; resets zero.
// - Second register bit 0 inverts the alignment signal; resets zero.
// - Second register bit 2 selects ground-referenced sample clock input mode.
// - Second register bit 1 selects ground-referenced alignment input mode.
// - Third register resets to 0x10; bits 2 and 0 are rail suppress enables.
// - A 24-bit read-only position status is reported.
// - Each suppress enable drives its rail noise suppression control.
`default_nettype none
module scc_sysref_ctrl
  import scc_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_b_i,
  input  wire logic [14:0]          addr_i,
  input  wire logic                 wr_en_i,
  input  wire logic [7:0]           wr_data_i,
  output var  logic [7:0]           rd_data_o,
  input  wire logic [SCC_POS_W-1:0] capture_position_status_i,
  input  wire logic                 align_edge_i,
  output var  logic                 align_edge_o,
  output wire logic                 align_processor_enable_o,
  output wire logic                 align_receiver_enable_o,
  output wire logic                 window_fine_step_o,
  output wire logic [3:0]           capture_delay_select_o,
  output wire logic                 align_polarity_invert_o,
  output wire logic                 sample_clock_pecl_mode_o,
  output wire logic                 align_input_pecl_mode_o,
  output wire logic                 analog_rail_noise_suppress_o,
  output wire logic                 clock_rail_noise_suppress_o
);
  import scc_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************
  wire logic       hit_capture = (addr_i == SCC_ADDR_CAPTURE);
  wire logic       hit_input   = (addr_i == SCC_ADDR_INPUT);
  wire logic       hit_supply  = (addr_i == SCC_ADDR_SUPPLY);
  wire logic       hit_pos0    = (addr_i == SCC_ADDR_POS);
  wire logic       hit_pos1    = (addr_i == SCC_ADDR_POS + 15'h0001);
  wire logic       hit_pos2    = (addr_i == SCC_ADDR_POS + 15'h0002);
  wire logic [7:0] capture_reg;
  wire logic [7:0] input_reg;
  wire logic [7:0] supply_reg;

  // ****************************************
  // Registers
  // ****************************************
  scc_reg8 #(.RESET_VALUE(SCC_RST_CAPTURE)) u_capture (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (wr_en_i && hit_capture),
    .wr_data_i (wr_data_i),
    .value_o   (capture_reg)
  );
  scc_reg8 #(.RESET_VALUE(SCC_RST_INPUT)) u_input (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (wr_en_i && hit_input),
    .wr_data_i (wr_data_i),
    .value_o   (input_reg)
  );
  scc_reg8 #(.RESET_VALUE(SCC_RST_SUPPLY)) u_supply (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .wr_en_i   (wr_en_i && hit_supply),
    .wr_data_i (wr_data_i),
    .value_o   (supply_reg)
  );

  // ****************************************
  // Control outputs
  // ****************************************
  assign align_processor_enable_o     = capture_reg[SCC_BIT_PROC_EN];
  assign align_receiver_enable_o      = capture_reg[SCC_BIT_RECV_EN];
  assign window_fine_step_o           = capture_reg[SCC_BIT_FINE];
  assign capture_delay_select_o       = capture_reg[SCC_SEL_MSB:0];
  assign align_polarity_invert_o      = input_reg[SCC_BIT_INVERT];
  assign align_input_pecl_mode_o      = input_reg[SCC_BIT_ALIGN_PE];
  assign sample_clock_pecl_mode_o     = input_reg[SCC_BIT_CLK_PE];
  assign analog_rail_noise_suppress_o = supply_reg[SCC_BIT_ANALOG];
  assign clock_rail_noise_suppress_o  = supply_reg[SCC_BIT_CLKRAIL];

  // ****************************************
  // Alignment edge gating
  // ****************************************
  wire logic next_align_edge = align_edge_i ^ input_reg[SCC_BIT_INVERT];
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      align_edge_o <= 1'b0;
    end else begin
      align_edge_o <= next_align_edge && capture_reg[SCC_BIT_PROC_EN]
                      && capture_reg[SCC_BIT_RECV_EN];
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  wire logic [7:0] next_rd_data =
    hit_capture ? capture_reg :
    hit_input   ? input_reg :
    hit_supply  ? supply_reg :
    hit_pos0    ? capture_position_status_i[7:0] :
    hit_pos1    ? capture_position_status_i[15:8] :
    hit_pos2    ? capture_position_status_i[23:16] :
                  8'h00;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else begin
      rd_data_o <= next_rd_data;
    end
  end
endmodule // scc_sysref_ctrl
`default_nettype wire

// File: logic/scc_pkg.sv
// Purpose: Constants for the alignment capture control register bank
// Assumes: Byte-wide registers on the serial configuration port
// Notes:   Offsets are register addresses on that port
`default_nettype none
package scc_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [14:0] SCC_ADDR_CAPTURE = 15'h0029;
  localparam logic [14:0] SCC_ADDR_INPUT   = 15'h002A;
  localparam logic [14:0] SCC_ADDR_SUPPLY  = 15'h002B;
  localparam logic [14:0] SCC_ADDR_POS     = 15'h002C;
  localparam int          SCC_POS_BYTES    = 3;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] SCC_RST_CAPTURE = 8'h80;
  localparam logic [7:0] SCC_RST_INPUT   = 8'h00;
  localparam logic [7:0] SCC_RST_SUPPLY  = 8'h10;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int SCC_BIT_PROC_EN  = 6;
  localparam int SCC_BIT_RECV_EN  = 5;
  localparam int SCC_BIT_FINE     = 4;
  localparam int SCC_SEL_MSB      = 3;
  localparam int SCC_BIT_INVERT   = 0;
  localparam int SCC_BIT_ALIGN_PE = 1;
  localparam int SCC_BIT_CLK_PE   = 2;
  localparam int SCC_BIT_ANALOG   = 2;
  localparam int SCC_BIT_CLKRAIL  = 0;
  localparam int SCC_POS_W        = 24;
endpackage : scc_pkg
`default_nettype wire

// File: logic/scc_reg8.sv
// Purpose: One byte-wide read/write control register
// Assumes: Write strobe from the same clock
// Notes:   Resets to a parameter value
`default_nettype none
module scc_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  output var  logic [7:0] value_o
);
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      value_o <= RESET_VALUE;
    end else if (wr_en_i) begin
      value_o <= wr_data_i;
    end
  end
endmodule // scc_reg8
`default_nettype wire

// File: verification/scc_sysref_ctrl_assertions.sv
// Purpose: Assertions for the alignment capture control bank
// Assumes: One clock, asynchronous active-low reset
// Notes:   Attached to the bank by bind
`default_nettype none
module scc_sysref_ctrl_chk
  import scc_pkg::*;
(
  input wire logic clk_i, rst_b_i, wr_en_i, align_edge_i, align_edge_o,
  input wire logic align_processor_enable_o, align_receiver_enable_o,
  input wire logic align_polarity_invert_o, analog_rail_noise_suppress_o,
  input wire logic [14:0] addr_i,
  input wire logic [7:0] wr_data_i, rd_data_o,
  input wire logic [3:0] capture_delay_select_o,
  input wire logic [SCC_POS_W-1:0] capture_position_status_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_cap; wr_en_i && addr_i == SCC_ADDR_CAPTURE; endsequence
  sequence s_cap_rd; s_cap ##1 (!wr_en_i && addr_i == SCC_ADDR_CAPTURE); endsequence
  chk_proc_recv_wr: assert property (s_cap |=>
    {align_processor_enable_o, align_receiver_enable_o} == $past(wr_data_i[6:5]))
    else $error("Enable bits differ from written byte");
  chk_delay_sel_wr: assert property (s_cap |=>
    capture_delay_select_o == $past(wr_data_i[3:0]))
    else $error("Delay select differs from written byte");
  chk_invert_wr: assert property (wr_en_i && addr_i == SCC_ADDR_INPUT |=>
    align_polarity_invert_o == $past(wr_data_i[0])) else $error("Invert bit wrong");
  chk_rail_wr: assert property (wr_en_i && addr_i == SCC_ADDR_SUPPLY |=>
    analog_rail_noise_suppress_o == $past(wr_data_i[2])) else $error("Rail bit wrong");
  chk_edge_gate: assert property (1'b1 |=> align_edge_o == $past(
    (align_edge_i ^ align_polarity_invert_o) & align_processor_enable_o
    & align_receiver_enable_o)) else $error("Edge output gating wrong");
  chk_pos_read: assert property (addr_i == SCC_ADDR_POS |=>
    rd_data_o == $past(capture_position_status_i[7:0])) else $error("Status read wrong");
  chk_cap_readback: assert property (s_cap_rd |=>
    rd_data_o == $past(wr_data_i, 2)) else $error("Readback differs from write");
  chk_ctrl_hold: assert property (!wr_en_i |=> $stable({align_processor_enable_o,
    capture_delay_select_o, align_polarity_invert_o})) else $error("Control moved");
endmodule // scc_sysref_ctrl_chk
bind scc_sysref_ctrl scc_sysref_ctrl_chk u_chk (.*);
`default_nettype wire

// File: verification/testbench.sv
// Purpose: Self-checking bench for the alignment capture control bank
// Assumes: 10 MHz clock, 12-cycle reset
// Notes:   Inputs change on rising edges, outputs sampled on falling edges
`default_nettype none
module testbench;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, rst_b_i, wr_en_i, align_edge_i;
  logic [14:0] addr_i;
  logic [7:0]  wr_data_i;
  logic [23:0] capture_position_status_i;
  wire logic [7:0] rd_data_o;
  wire logic [3:0] capture_delay_select_o;
  wire logic align_edge_o, align_processor_enable_o, align_receiver_enable_o;
  wire logic window_fine_step_o, align_polarity_invert_o, sample_clock_pecl_mode_o;
  wire logic align_input_pecl_mode_o, analog_rail_noise_suppress_o, clock_rail_noise_suppress_o;
  int bad_count, n_checks;
  scc_sysref_ctrl dut (.*);
  task chk(input logic [23:0] seen, input logic [23:0] exp, input string name);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [14:0] a, input logic [7:0] d);
    @(posedge clk_i) {addr_i, wr_data_i, wr_en_i} <= {a, d, 1'b1};
    @(posedge clk_i) wr_en_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task rd(input logic [14:0] a, input logic [7:0] e);
    @(posedge clk_i) addr_i <= a;
    @(posedge clk_i);
    @(negedge clk_i) chk(rd_data_o, e, "rd_data");
  endtask
  task t_reset;
    rd(SCC_ADDR_CAPTURE, 8'h80);
    rd(SCC_ADDR_INPUT, 8'h00);
    rd(SCC_ADDR_SUPPLY, 8'h10);
    chk({align_processor_enable_o, align_receiver_enable_o, window_fine_step_o,
      capture_delay_select_o, align_polarity_invert_o, sample_clock_pecl_mode_o,
      align_input_pecl_mode_o, analog_rail_noise_suppress_o, clock_rail_noise_suppress_o},
      24'h0, "reset_outputs");
    $display("done t_reset");
  endtask
  task t_cap;
    wr(SCC_ADDR_CAPTURE, 8'hE3);
    chk({align_processor_enable_o, align_receiver_enable_o, window_fine_step_o,
      capture_delay_select_o}, 24'h63, "capture_a");
    rd(SCC_ADDR_CAPTURE, 8'hE3);
    wr(SCC_ADDR_CAPTURE, 8'h9F);
    chk({align_processor_enable_o, align_receiver_enable_o, window_fine_step_o,
      capture_delay_select_o}, 24'h1F, "capture_b");
    $display("done t_cap");
  endtask
  task t_inp_sup;
    wr(SCC_ADDR_INPUT, 8'h06);
    chk({sample_clock_pecl_mode_o, align_input_pecl_mode_o, align_polarity_invert_o},
      24'h6, "input_modes");
    wr(SCC_ADDR_INPUT, 8'h02);
    chk(sample_clock_pecl_mode_o, 24'h0, "clock_mode");
    rd(SCC_ADDR_INPUT, 8'h02);
    wr(SCC_ADDR_SUPPLY, 8'h15);
    chk({analog_rail_noise_suppress_o, clock_rail_noise_suppress_o}, 24'h3, "rails");
    wr(SCC_ADDR_SUPPLY, 8'h14);
    chk(clock_rail_noise_suppress_o, 24'h0, "clock_rail");
    rd(SCC_ADDR_SUPPLY, 8'h14);
    $display("done t_inp_sup");
  endtask
  task t_pos;
    capture_position_status_i <= 24'hA5C33C;
    wr(SCC_ADDR_POS, 8'hFF);
    rd(SCC_ADDR_POS, 8'h3C);
    rd(15'h002D, 8'hC3);
    rd(15'h002E, 8'hA5);
    rd(15'h0040, 8'h00);
    wr(SCC_ADDR_CAPTURE, 8'h80 | {4'h0, capture_position_status_i[3:0]});
    chk(capture_delay_select_o, 24'hC, "sel_from_status");
    $display("done t_pos");
  endtask
  task t_edge;
    int i;
    for (i = 0; i < 3; i++) begin
      wr(SCC_ADDR_CAPTURE, (i == 0) ? 8'h80 : (i == 1) ? 8'hA0 : 8'hE0);
      @(posedge clk_i) align_edge_i <= 1'b1;
      @(posedge clk_i) align_edge_i <= 1'b0;
      @(negedge clk_i) chk(align_edge_o, 24'(i == 2), "edge_gate");
    end
    wr(SCC_ADDR_INPUT, 8'h01);
    @(negedge clk_i) chk(align_edge_o, 24'h1, "edge_invert");
    $display("done t_edge");
  endtask
  task tally_and_finish;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    {rst_b_i, wr_en_i, align_edge_i, addr_i, wr_data_i, capture_position_status_i} = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset;
    t_cap;
    t_inp_sup;
    t_pos;
    t_edge;
    tally_and_finish;
  end
  initial begin
    #2000000;
    bad_count++;
    tally_and_finish;
  end
endmodule // testbench
`default_nettype wire
